// ### logic/dmc_flag.sv
// Flag cleared by a zero written after it was read as one
module dmc_flag (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic set,
	input wire logic hw_clr,
	input wire logic rd_snap,
	input wire logic wr_stb,
	input wire logic wr_bit,
	output logic q,
	output logic armed
);
	logic q_reg, q_next;
	logic arm_reg, arm_next;

	// Set wins over every clear; a written one keeps the flag but disarms it
	always_comb begin
		q_next = q_reg;
		arm_next = arm_reg;
		if (wr_stb && !wr_bit && arm_reg)
			q_next = 1'b0;
		if (hw_clr)
			q_next = 1'b0;
		if (set)
			q_next = 1'b1;
		if (wr_stb)
			arm_next = 1'b0;
		if (rd_snap)
			arm_next = q_reg;
		if (!q_next)
			arm_next = 1'b0;
	end

	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_reg <= 1'b0;
			arm_reg <= 1'b0;
		end else begin
			q_reg <= q_next;
			arm_reg <= arm_next;
		end
	end

	assign q = q_reg;
	assign armed = arm_reg;
endmodule // dmc_flag

// ### logic/dmc_size_chk.sv
// Amount per request and transfer-size error decode
module dmc_size_chk #(
	parameter int CNT_W = 32
) (
	input dmc_pkg::dmc_mode_s cfg,
	input wire logic [CNT_W-1:0] cnt,
	input wire logic [CNT_W-1:0] blk,
	output logic [CNT_W-1:0] amount,
	output logic err,
	output logic bad
);
	import dmc_pkg::*;
	logic [31:0] acc;

	// Block mode moves a block, others one access
	always_comb begin
		acc = size_bytes(cfg.size);
		if (cfg.mode == MD_BLOCK)
			amount = blk;
		else
			amount = acc[CNT_W-1:0];
		err = cnt < amount;
		bad = (cfg.size == SZ_BAD) || (cfg.mode == MD_BAD);
	end
endmodule // dmc_size_chk

// ### logic/dmc_top.sv
// DMA channel mode register, interrupt flags and AXI4-Lite slave
// Behaviour
// - Transfer-end flag sets when the counter reaches zero on completion.
// - Transfer-end flag clears on enable set or zero written after read.
// - Size field 00 byte, 01 16 bits, 10 32 bits, 11 prohibited.
// - Mode field 00 normal, 01 block, 10 repeat, 11 prohibited.
// - Size error with its enable stops the channel and sets escape flag.
// - Normal or repeat: counter below the access size is a size error.
// - Block: counter below the block size is a size error.
// - Escape request is high while escape flag and its enable are one.
// - Transfer-end request is high while its flag and enable are one.
// - Bit 10 is reserved, reads zero and ignores writes.
// - Escape flag also sets on repeat end or area overflow end.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
module dmc_top #(
	parameter int CNT_W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [dmc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [dmc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input dmc_pkg::dmc_evt_s evt,
	output logic req_ack,
	output logic xfer_enable,
	output dmc_pkg::dmc_mode_s cfg,
	output logic [CNT_W-1:0] xfer_counter,
	output logic escape_irq,
	output logic xfer_end_irq,
	output logic irq
);
	import dmc_pkg::*;

	// Width check
	if (CNT_W < 8 || CNT_W > 32) begin : g_bad_w
		$error("CNT_W must lie between 8 and 32");
	end

	dmc_wstate_e ws_reg, ws_next;
	logic aw_h_reg, aw_h_next;
	logic w_h_reg, w_h_next;
	logic [ADDR_W-1:0] aw_a_reg, aw_a_next;
	logic [31:0] w_d_reg, w_d_next;
	logic [3:0] w_s_reg, w_s_next;
	logic [1:0] b_r_reg, b_r_next;
	logic rv_reg, rv_next;
	logic [31:0] rd_reg, rd_next;
	logic [1:0] rr_reg, rr_next;
	dmc_mode_s cfg_reg, cfg_next;
	logic xen_reg, xen_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [CNT_W-1:0] blk_reg, blk_next;
	logic [ST_W-1:0] st_reg, st_next;
	logic [ST_W-1:0] msk_reg, msk_next;
	logic wr_do, ar_hs, rd_mode, wr_mode, wr_ctrl;
	logic [31:0] wmask, mode_word, cnt_w, blk_w, cnt_wr, blk_wr;
	logic [CNT_W-1:0] amount;
	logic size_err, cfg_bad, done_ok, xend_set, tse_stop, sw_en_set;
	logic [1:0] fl_set, fl_q, fl_arm;
	logic [ST_W-1:0] st_ev;

	// Bus decode strobes
	assign wr_do = (ws_reg == WS_IDLE) && aw_h_reg && w_h_reg;
	assign ar_hs = arvalid && arready;
	assign rd_mode = ar_hs && (araddr == OFS_MODE);
	assign wr_mode = wr_do && (aw_a_reg == OFS_MODE);
	assign wr_ctrl = wr_do && (aw_a_reg == OFS_CTRL) && w_s_reg[0];
	assign wmask = strb_mask(w_s_reg);
	assign cnt_wr = (cnt_w & ~wmask) | (w_d_reg & wmask); // Byte merge
	assign blk_wr = (blk_w & ~wmask) | (w_d_reg & wmask);
	assign sw_en_set = wr_ctrl && w_d_reg[BIT_XEN];

	// Size error decode for the current settings
	dmc_size_chk #(
		.CNT_W(CNT_W)
	) u_chk (
		.cfg(cfg_reg),
		.cnt(cnt_reg),
		.blk(blk_reg),
		.amount(amount),
		.err(size_err),
		.bad(cfg_bad)
	);

	// Channel events
	assign done_ok = evt.done && xen_reg;
	assign xend_set = done_ok && (cnt_reg <= amount);
	assign tse_stop = evt.req && xen_reg && cfg_reg.tse_en && size_err;
	assign req_ack = evt.req && xen_reg && !cfg_bad && !tse_stop;
	assign fl_set[0] = xend_set;
	assign fl_set[1] = tse_stop || evt.rpt_end || evt.ovf_end;

	// Both flags clear by read-then-zero or by setting the enable
	for (genvar gi = 0; gi < 2; gi++) begin : g_flag
		localparam int FB = (gi == 0) ? BIT_XEF : BIT_ESC;
		dmc_flag u_flag (
			.aclk(aclk),
			.aresetn(aresetn),
			.set(fl_set[gi]),
			.hw_clr(sw_en_set),
			.rd_snap(rd_mode),
			.wr_stb(wr_mode && w_s_reg[2]),
			.wr_bit(w_d_reg[FB]),
			.q(fl_q[gi]),
			.armed(fl_arm[gi])
		);
	end

	// Interrupt requests toward the processor
	assign escape_irq = fl_q[1] && cfg_reg.esc_en;
	assign xfer_end_irq = fl_q[0] && cfg_reg.xend_en;
	assign st_ev = {tse_stop, fl_set[1], xend_set};
	assign irq = |(st_reg & msk_reg);

	// Read image of the mode register, reserved bits zero
	always_comb begin
		mode_word = 32'h0;
		mode_word[BIT_ESC] = fl_q[1];
		mode_word[BIT_XEF] = fl_q[0];
		mode_word[BIT_SZ_LO+1:BIT_SZ_LO] = cfg_reg.size;
		mode_word[BIT_MD_LO+1:BIT_MD_LO] = cfg_reg.mode;
		mode_word[BIT_TSE] = cfg_reg.tse_en;
		mode_word[BIT_RSV] = 1'b0;
		mode_word[BIT_ESE] = cfg_reg.esc_en;
		mode_word[BIT_XEE] = cfg_reg.xend_en;
		cnt_w = 32'h0;
		cnt_w[CNT_W-1:0] = cnt_reg;
		blk_w = 32'h0;
		blk_w[CNT_W-1:0] = blk_reg;
	end

	// Write channel: address and data in either order
	always_comb begin
		ws_next = ws_reg;
		aw_h_next = aw_h_reg;
		w_h_next = w_h_reg;
		aw_a_next = aw_a_reg;
		w_d_next = w_d_reg;
		w_s_next = w_s_reg;
		b_r_next = b_r_reg;
		if (awvalid && awready) begin
			aw_h_next = 1'b1;
			aw_a_next = awaddr;
		end
		if (wvalid && wready) begin
			w_h_next = 1'b1;
			w_d_next = wdata;
			w_s_next = wstrb;
		end
		unique case (ws_reg)
			WS_IDLE: begin
				if (wr_do) begin
					ws_next = WS_RESP;
					unique case (aw_a_reg)
						OFS_MODE, OFS_CTRL, OFS_CNT,
						OFS_BLK, OFS_STAT, OFS_MASK:
							b_r_next = RESP_OKAY;
						default: b_r_next = RESP_SLVERR;
					endcase
				end
			end
			WS_RESP: begin
				if (bready) begin
					ws_next = WS_IDLE;
					aw_h_next = 1'b0;
					w_h_next = 1'b0;
				end
			end
			default: ws_next = WS_IDLE;
		endcase
	end

	assign awready = (ws_reg == WS_IDLE) && !aw_h_reg;
	assign wready = (ws_reg == WS_IDLE) && !w_h_reg;
	assign bvalid = (ws_reg == WS_RESP);
	assign bresp = b_r_reg;

	// Read channel: data one cycle after the address is taken
	always_comb begin
		rv_next = rv_reg;
		rd_next = rd_reg;
		rr_next = rr_reg;
		if (rv_reg && rready)
			rv_next = 1'b0;
		if (ar_hs) begin
			rv_next = 1'b1;
			rr_next = RESP_OKAY;
			unique case (araddr)
				OFS_MODE: rd_next = mode_word;
				OFS_CTRL: rd_next = {31'h0, xen_reg};
				OFS_CNT: rd_next = cnt_w;
				OFS_BLK: rd_next = blk_w;
				OFS_STAT: rd_next = {29'h0, st_reg};
				OFS_MASK: rd_next = {29'h0, msk_reg};
				default: begin
					rd_next = 32'h0;
					rr_next = RESP_SLVERR;
				end
			endcase
		end
	end

	assign arready = !rv_reg;
	assign rvalid = rv_reg;
	assign rdata = rd_reg;
	assign rresp = rr_reg;

	// Channel registers: settings, enable, counter, interrupts
	always_comb begin
		cfg_next = cfg_reg;
		xen_next = xen_reg;
		cnt_next = cnt_reg;
		blk_next = blk_reg;
		msk_next = msk_reg;
		st_next = st_reg;
		if (wr_mode && w_s_reg[1]) begin
			cfg_next.size = dmc_size_e'(w_d_reg[BIT_SZ_LO+1:BIT_SZ_LO]);
			cfg_next.mode = dmc_mode_e'(w_d_reg[BIT_MD_LO+1:BIT_MD_LO]);
			cfg_next.tse_en = w_d_reg[BIT_TSE];
			cfg_next.esc_en = w_d_reg[BIT_ESE];
			cfg_next.xend_en = w_d_reg[BIT_XEE];
		end
		if (wr_ctrl)
			xen_next = w_d_reg[BIT_XEN];
		if (tse_stop || xend_set)
			xen_next = 1'b0;
		if (done_ok)
			cnt_next = xend_set ? '0 : cnt_reg - amount;
		if (wr_do && aw_a_reg == OFS_CNT)
			cnt_next = cnt_wr[CNT_W-1:0];
		if (wr_do && aw_a_reg == OFS_BLK)
			blk_next = blk_wr[CNT_W-1:0];
		if (wr_do && aw_a_reg == OFS_MASK && w_s_reg[0])
			msk_next = w_d_reg[ST_W-1:0];
		if (wr_do && aw_a_reg == OFS_STAT && w_s_reg[0])
			st_next = st_reg & ~w_d_reg[ST_W-1:0];
		st_next = st_next | st_ev;
	end

	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ws_reg <= WS_IDLE;
			aw_h_reg <= 1'b0;
			w_h_reg <= 1'b0;
			aw_a_reg <= '0;
			w_d_reg <= 32'h0;
			w_s_reg <= 4'h0;
			b_r_reg <= RESP_OKAY;
			rv_reg <= 1'b0;
			rd_reg <= 32'h0;
			rr_reg <= RESP_OKAY;
			cfg_reg <= '0;
			xen_reg <= 1'b0;
			cnt_reg <= '0;
			blk_reg <= BLK_RST[CNT_W-1:0];
			st_reg <= '0;
			msk_reg <= MASK_RST;
		end else begin
			ws_reg <= ws_next;
			aw_h_reg <= aw_h_next;
			w_h_reg <= w_h_next;
			aw_a_reg <= aw_a_next;
			w_d_reg <= w_d_next;
			w_s_reg <= w_s_next;
			b_r_reg <= b_r_next;
			rv_reg <= rv_next;
			rd_reg <= rd_next;
			rr_reg <= rr_next;
			cfg_reg <= cfg_next;
			xen_reg <= xen_next;
			cnt_reg <= cnt_next;
			blk_reg <= blk_next;
			st_reg <= st_next;
			msk_reg <= msk_next;
		end
	end

	assign xfer_enable = xen_reg;
	assign cfg = cfg_reg;
	assign xfer_counter = cnt_reg;

	// Checks on flag, enable and request behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_xend_set_zero: assert property (
		evt.done && xen_reg && cnt_reg <= amount
		|=> fl_q[0] && cnt_reg == '0 && !xen_reg)
		else $error("end flag not set at count zero");
	a_xend_en_clr: assert property (
		sw_en_set && !xend_set |=> !fl_q[0])
		else $error("end flag kept after enable set");
	a_xend_rd_clr: assert property (
		wr_mode && w_s_reg[2] && !w_d_reg[BIT_XEF] && fl_arm[0]
		&& !xend_set |=> !fl_q[0])
		else $error("end flag kept after read then zero");
	a_xend_w1_keep: assert property (
		fl_q[0] && wr_mode && w_d_reg[BIT_XEF] && !sw_en_set
		|=> fl_q[0])
		else $error("end flag lost on written one");
	a_mode_fields: assert property (
		wr_mode && w_s_reg[1] |=> cfg_reg.size ==
		$past(w_d_reg[BIT_SZ_LO+1:BIT_SZ_LO]) && cfg_reg.mode ==
		$past(w_d_reg[BIT_MD_LO+1:BIT_MD_LO]))
		else $error("mode fields not stored");
	a_size_stop: assert property (
		evt.req && xen_reg && cfg_reg.tse_en && size_err
		|-> !req_ack ##1 (!xen_reg && fl_q[1] && st_reg[ST_TSE]))
		else $error("size error did not stop channel");
	a_access_err: assert property (
		cfg_reg.mode != MD_BLOCK && cfg_reg.mode != MD_BAD &&
		cnt_reg < size_bytes(cfg_reg.size) |-> size_err)
		else $error("access size error missed");
	a_block_err: assert property (
		cfg_reg.mode == MD_BLOCK |-> size_err == (cnt_reg < blk_reg))
		else $error("block size error wrong");
	a_esc_irq: assert property (
		$fell(cfg_reg.esc_en) || $fell(fl_q[1]) |-> !escape_irq)
		else $error("escape request not dropped");
	a_xend_irq: assert property (
		$rose(fl_q[0]) && cfg_reg.xend_en |-> xfer_end_irq)
		else $error("end request missing");
	a_rsv_zero: assert property (
		rv_reg && $past(rd_mode) |-> !rd_reg[BIT_RSV])
		else $error("reserved bit read as one");
	a_rpt_esc: assert property (
		evt.rpt_end || evt.ovf_end |=> fl_q[1] [*1] ##0 st_reg[ST_ESC])
		else $error("escape flag not set on repeat end");

	c_xend: cover property (xend_set ##1 xfer_end_irq);
	c_size_err: cover property (tse_stop ##1 escape_irq);
	c_rd_clr: cover property (fl_arm[0] ##[1:20] (wr_mode && !fl_q[0]));
	c_irq: cover property ($rose(irq));
endmodule // dmc_top

// ### pkg/dmc_pkg.sv
// Shared constants, types and helpers of the DMA channel mode block
package dmc_pkg;
	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_CNT = 8'h08;
	localparam logic [7:0] OFS_BLK = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	// Field positions in the mode control register, enable bit in the control register
	localparam int BIT_ESC = 17;
	localparam int BIT_XEF = 16;
	localparam int BIT_SZ_LO = 14;
	localparam int BIT_MD_LO = 12;
	localparam int BIT_TSE = 11;
	localparam int BIT_RSV = 10;
	localparam int BIT_ESE = 9;
	localparam int BIT_XEE = 8;
	localparam int BIT_XEN = 0;
	// Status and mask bit positions
	localparam int ST_XEND = 0;
	localparam int ST_ESC = 1;
	localparam int ST_TSE = 2;
	localparam int ST_W = 3;
	// Reset values
	localparam logic [ST_W-1:0] MASK_RST = 3'h0;
	localparam logic [31:0] BLK_RST = 32'h0000_0001;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2, SZ_BAD = 2'h3
	} dmc_size_e;
	typedef enum logic [1:0] {
		MD_NORMAL = 2'h0, MD_BLOCK = 2'h1, MD_REPEAT = 2'h2, MD_BAD = 2'h3
	} dmc_mode_e;
	typedef enum logic [1:0] {
		WS_IDLE = 2'h1, WS_RESP = 2'h2
	} dmc_wstate_e;

	// Software settings of the channel
	typedef struct packed {
		dmc_size_e size;
		dmc_mode_e mode;
		logic tse_en;
		logic esc_en;
		logic xend_en;
	} dmc_mode_s;
	// Events from the rest of the channel
	typedef struct packed {
		logic req;
		logic done;
		logic rpt_end;
		logic ovf_end;
	} dmc_evt_s;

	// Byte count of one access
	function automatic logic [31:0] size_bytes(dmc_size_e s);
		unique case (s)
			SZ_WORD: size_bytes = 32'h0000_0002;
			SZ_LONG: size_bytes = 32'h0000_0004;
			default: size_bytes = 32'h0000_0001;
		endcase
	endfunction

	// Bit mask from byte strobes
	function automatic logic [31:0] strb_mask(logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction
endpackage

// ### tb/dmc_chan_model.sv
// Channel-side model issuing one-cycle event pulses and noting acks
module dmc_chan_model (
	input wire logic aclk,
	input wire logic aresetn,
	input dmc_pkg::dmc_evt_s cmd,
	input wire logic req_ack,
	output dmc_pkg::dmc_evt_s evt,
	output logic ack_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	import dmc_pkg::*;

	// Events last one cycle, idle at zero between commands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt <= '0;
			ack_seen <= 1'b0;
		end else begin
			evt <= cmd;
			ack_seen <= evt.req & req_ack; // Ack only counts in req cycle
		end
	end
endmodule // dmc_chan_model

// ### tb/dmc_top_test.sv
// Self-checking bench for the channel mode block
module dmc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dmc_pkg::*;

	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	dmc_evt_s cmd = '0, evt;
	dmc_mode_s cfg;
	logic req_ack, xfer_enable, escape_irq, xfer_end_irq, irq, ack_seen;
	logic [31:0] xfer_counter, d;
	logic [1:0] r, wr_resp;
	logic a;
	int mismatches = 0, checks = 0, cyc = 0;
	logic [31:0] row_in[4] = '{32'h0003_0F00, 32'h0000_4200,
		32'h0000_9100, 32'h0000_2800};
	logic [31:0] row_rd[4] = '{32'h0000_0B00, 32'h0000_4200,
		32'h0000_9100, 32'h0000_2800};
	logic [6:0] row_cfg[4] = '{7'h07, 7'h22, 7'h49, 7'h14};

	dmc_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .evt(evt), .req_ack(req_ack),
		.xfer_enable(xfer_enable), .cfg(cfg), .xfer_counter(xfer_counter),
		.escape_irq(escape_irq), .xfer_end_irq(xfer_end_irq), .irq(irq));
	dmc_chan_model partner (.aclk(aclk), .aresetn(aresetn), .cmd(cmd),
		.req_ack(req_ack), .evt(evt), .ack_seen(ack_seen));

	// Clock and hang guard
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Write one word: hold each channel until taken, then await the answer
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		logic aw, w, b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w || !b) begin
			@(negedge aclk);
			aw = aw && !(awvalid && awready);
			w = w && !(wvalid && wready);
			b = bvalid;
			wr_resp = bresp;
			@(posedge aclk);
			if (!aw) awvalid <= 1'b0;
			if (!w) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(negedge aclk); // Let outputs settle before any check
	endtask

	// Read one word with its response code
	task automatic rd(input logic [7:0] ad, output logic [31:0] dt,
		output logic [1:0] rs);
		logic t;
		t = 1'b0;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!t) begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		t = 1'b0;
		while (!t) begin
			@(negedge aclk);
			t = rvalid;
			dt = rdata;
			rs = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
		@(negedge aclk); // Let outputs settle before any check
	endtask

	// One event pulse through the partner; returns whether req was acked
	task automatic pulse(input logic [3:0] e, output logic ak);
		@(posedge aclk);
		cmd <= e;
		@(posedge aclk);
		cmd <= '0;
		@(posedge aclk);
		@(negedge aclk);
		ak = ack_seen;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_MODE, d, r);
		chk(d, 32'h0);
		rd(OFS_BLK, d, r);
		chk(d, 32'h1);
		rd(8'h40, d, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h40, 32'h0);
		chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
		for (int i = 0; i < 4; i++) begin
			wr(OFS_MODE, row_in[i]);
			rd(OFS_MODE, d, r);
			chk(d, row_rd[i]);
			chk({25'h0, cfg}, {25'h0, row_cfg[i]});
		end
		wr(OFS_MODE, 32'h0000_0100);
		chk({30'h0, wr_resp}, {30'h0, RESP_OKAY});
		wr(OFS_CNT, 32'h4);
		wr(OFS_CTRL, 32'h1);
		repeat (4) pulse(4'h4, a);
		chk(xfer_counter, 32'h0);
		chk({31'h0, xfer_enable}, 32'h0);
		chk({31'h0, xfer_end_irq}, 32'h1);
		rd(OFS_MODE, d, r);
		chk(d, 32'h0001_0100);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_MASK, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_MODE, 32'h0001_0100);
		rd(OFS_MODE, d, r);
		chk(d, 32'h0001_0100);
		wr(OFS_MODE, 32'h0000_0100);
		chk({31'h0, xfer_end_irq}, 32'h0);
		wr(OFS_MODE, 32'h0000_8A00);
		wr(OFS_CNT, 32'h2);
		wr(OFS_CTRL, 32'h1);
		pulse(4'h8, a);
		chk({31'h0, a}, 32'h0);
		chk({31'h0, xfer_enable}, 32'h0);
		chk({31'h0, escape_irq}, 32'h1);
		rd(OFS_STAT, d, r);
		chk(d, 32'h6);
		wr(OFS_MODE, 32'h0000_8800);
		chk({31'h0, escape_irq}, 32'h0);
		wr(OFS_CTRL, 32'h1);
		rd(OFS_MODE, d, r);
		chk(d, 32'h0000_8800);
		wr(OFS_BLK, 32'h8);
		wr(OFS_MODE, 32'h0000_1A00);
		wr(OFS_CNT, 32'h4);
		wr(OFS_CTRL, 32'h1);
		pulse(4'h8, a);
		chk({31'h0, a}, 32'h0);
		chk({31'h0, escape_irq}, 32'h1);
		wr(OFS_CNT, 32'h8);
		wr(OFS_CTRL, 32'h1);
		chk({31'h0, escape_irq}, 32'h0);
		pulse(4'h8, a);
		chk({31'h0, a}, 32'h1);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_MODE, 32'h0000_3A00);
		pulse(4'h8, a);
		chk({31'h0, a}, 32'h0);
		chk({31'h0, escape_irq}, 32'h0);
		wr(OFS_MODE, 32'h0000_C200);
		pulse(4'h8, a);
		chk({31'h0, a}, 32'h0);
		wr(OFS_MODE, 32'h0000_0200);
		pulse(4'h2, a);
		chk({31'h0, escape_irq}, 32'h1);
		wr(OFS_CTRL, 32'h1);
		chk({31'h0, escape_irq}, 32'h0);
		pulse(4'h1, a);
		chk({31'h0, escape_irq}, 32'h1);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_MODE, d, r);
		chk(d, 32'h0);
		chk({31'h0, escape_irq}, 32'h0);
		tally_and_finish();
	end
endmodule // dmc_top_test
